// File: verilog/crb_pkg.sv
package crb_pkg;
	localparam int ADDR_W = 24;
	localparam int DATA_W = 32;
	localparam int STRB_W = DATA_W / 8;
	localparam int HALF_W = 16;
	localparam int OPS_W = 13;

	// Capability register byte offsets
	localparam logic [ADDR_W-1:0] OFF_ASM_INFO = 24'h00000C;
	localparam logic [ADDR_W-1:0] OFF_FEATURES = 24'h000010;
	localparam logic [ADDR_W-1:0] OFF_SWITCH_PORT = 24'h000014;
	localparam logic [ADDR_W-1:0] OFF_SRC_OPS = 24'h000018;
	localparam logic [ADDR_W-1:0] OFF_DST_OPS = 24'h00001C;
	localparam logic [ADDR_W-1:0] OFF_RSVD_FIRST = 24'h000020;
	localparam logic [ADDR_W-1:0] OFF_CAP_LAST = 24'h00003C;
	localparam logic [ADDR_W-1:0] WORD_MASK = 24'hFFFFFC;

	// Field layout of the assembly information word
	localparam int ASM_REV_LSB = 16;
	localparam int EXT_PTR_LSB = 0;
	localparam logic [HALF_W-1:0] EXT_PTR_DEFAULT = 16'h0100;

	// Field layout of the features word
	localparam int FEAT_BRIDGE_BIT = 31;
	localparam int FEAT_MEMORY_BIT = 30;
	localparam int FEAT_PROC_BIT = 29;
	localparam int FEAT_SWITCH_BIT = 28;
	localparam int FEAT_MULTIPORT_BIT = 27;
	localparam int FEAT_CRF_BIT = 5;
	localparam int FEAT_LARGE_SYS_BIT = 4;
	localparam int FEAT_EXT_FEAT_BIT = 3;
	localparam int FEAT_EXT_ADDR_LSB = 0;
	localparam logic FEAT_SWITCH_VAL = 1'b0;
	localparam logic FEAT_MULTIPORT_VAL = 1'b0;
	localparam logic FEAT_EXT_FEAT_VAL = 1'b1;
	localparam logic [2:0] EXT_ADDR_34 = 3'h1;

	// Field layout of both operations words: bits 15 down to 3
	localparam int OPS_LSB = 3;
	localparam int OPS_MSB = OPS_LSB + OPS_W - 1;
	localparam int OPS_PORT_WRITE_BIT = 2;
	localparam logic OPS_PORT_WRITE_VAL = 1'b0;

	localparam logic [DATA_W-1:0] WORD_ZERO = 32'h00000000;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	typedef enum logic [2:0] {
		SEL_NONE,
		SEL_ZERO,
		SEL_ASM,
		SEL_FEAT,
		SEL_SRC,
		SEL_DST
	} crb_sel_t;
endpackage : crb_pkg

// File: verilog/crb_dec_if.sv
`timescale 1ns/1ps
interface crb_dec_if;
	logic [crb_pkg::ADDR_W-1:0] addr;
	crb_pkg::crb_sel_t sel;

	modport req (output addr, input sel);
	modport dec (input addr, output sel);
endinterface : crb_dec_if

// File: verilog/crb_decode.sv
`timescale 1ns/1ps
module crb_decode (
	crb_dec_if.dec dec
);
	import crb_pkg::*;

	wire [ADDR_W-1:0] word_addr;
	wire in_cap_space;
	wire hit_asm;
	wire hit_feat;
	wire hit_src;
	wire hit_dst;

	// Byte lanes inside a word do not matter: the whole word is returned
	assign word_addr = dec.addr & WORD_MASK;
	assign in_cap_space = (word_addr >= OFF_ASM_INFO) && (word_addr <= OFF_CAP_LAST);
	assign hit_asm = (word_addr == OFF_ASM_INFO);
	assign hit_feat = (word_addr == OFF_FEATURES);
	assign hit_src = (word_addr == OFF_SRC_OPS);
	assign hit_dst = (word_addr == OFF_DST_OPS);

	// Switch port word and the reserved tail answer zero
	assign dec.sel = hit_asm ? SEL_ASM :
		hit_feat ? SEL_FEAT :
		hit_src ? SEL_SRC :
		hit_dst ? SEL_DST :
		in_cap_space ? SEL_ZERO :
		SEL_NONE;
endmodule : crb_decode

// File: verilog/crb_reg_bank.sv
`timescale 1ns/1ps
// Summary of operation
// - Assembly info upper half returns the build-time assembly revision, read-only.
// - Assembly info lower half returns build-time extended features pointer, default 0x0100.
// - Feature bits 31, 30, 29 report bridge, memory, processor roles from build.
// - Feature bits 28 switch and 27 multiport always read zero.
// - Feature bit 4 reports large system; when set, 16-bit device IDs are used.
// - Feature bit 5 reports critical request flow support from build configuration.
// - Feature bit 3 always reads one: extended features pointer is valid.
// - Feature bits 2 to 0 read 001: only 34-bit addressing.
// - Feature bits 26 to 7 and bit 6 always read zero.
// - Switch port word carries no switching information since switch bit is zero.
// - Source operations bits 15 to 3 report issuable transaction types from build.
// - Operation words are informational only and steer no endpoint behaviour.
// - Source operations bits 31 to 16 and 1 to 0 always read zero.
// - Port-write bit 2 reads zero in both operations words.
// - Destination operations uses the same layout, reporting acceptable transaction types.
// - Destination operations bits 31 to 16 and 1 to 0 always read zero.
// - All capability registers are read-only, living beside the command and status registers.
module crb_reg_bank #(
	parameter logic [crb_pkg::HALF_W-1:0] ASM_REVISION = 16'h0000,
	parameter logic [crb_pkg::HALF_W-1:0] EXT_FEAT_PTR = crb_pkg::EXT_PTR_DEFAULT,
	parameter logic ROLE_BRIDGE = 1'b0,
	parameter logic ROLE_MEMORY = 1'b1,
	parameter logic ROLE_PROCESSOR = 1'b0,
	parameter logic CRF_SUPPORT = 1'b0,
	parameter logic LARGE_SYSTEM = 1'b0,
	parameter logic [crb_pkg::OPS_W-1:0] SRC_OPS = 13'h1FFF,
	parameter logic [crb_pkg::OPS_W-1:0] DST_OPS = 13'h1FFF
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic ce,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [crb_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [crb_pkg::DATA_W-1:0] s_axi_wdata,
	input wire logic [crb_pkg::STRB_W-1:0] s_axi_wstrb,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [crb_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [crb_pkg::DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic dev_id_16b
);
	import crb_pkg::*;

	// Constant register images
	wire [DATA_W-1:0] asm_info_word;
	wire [DATA_W-1:0] features_word;
	wire [DATA_W-1:0] src_ops_word;
	wire [DATA_W-1:0] dst_ops_word;

	assign asm_info_word[ASM_REV_LSB +: HALF_W] = ASM_REVISION;
	assign asm_info_word[EXT_PTR_LSB +: HALF_W] = EXT_FEAT_PTR;

	genvar gi;
	generate
		for (gi = 0; gi < DATA_W; gi++) begin : g_word_bits
			if (gi == FEAT_BRIDGE_BIT) begin : g_bridge
				assign features_word[gi] = ROLE_BRIDGE;
			end else if (gi == FEAT_MEMORY_BIT) begin : g_memory
				assign features_word[gi] = ROLE_MEMORY;
			end else if (gi == FEAT_PROC_BIT) begin : g_proc
				assign features_word[gi] = ROLE_PROCESSOR;
			end else if (gi == FEAT_SWITCH_BIT) begin : g_switch
				assign features_word[gi] = FEAT_SWITCH_VAL;
			end else if (gi == FEAT_MULTIPORT_BIT) begin : g_multiport
				assign features_word[gi] = FEAT_MULTIPORT_VAL;
			end else if (gi == FEAT_CRF_BIT) begin : g_crf
				assign features_word[gi] = CRF_SUPPORT;
			end else if (gi == FEAT_LARGE_SYS_BIT) begin : g_large
				assign features_word[gi] = LARGE_SYSTEM;
			end else if (gi == FEAT_EXT_FEAT_BIT) begin : g_extfeat
				assign features_word[gi] = FEAT_EXT_FEAT_VAL;
			end else if (gi < FEAT_EXT_FEAT_BIT) begin : g_extaddr
				assign features_word[gi] = EXT_ADDR_34[gi - FEAT_EXT_ADDR_LSB];
			end else begin : g_feat_rsvd
				assign features_word[gi] = 1'b0;
			end

			if (gi >= OPS_LSB && gi <= OPS_MSB) begin : g_ops
				assign src_ops_word[gi] = SRC_OPS[gi - OPS_LSB];
				assign dst_ops_word[gi] = DST_OPS[gi - OPS_LSB];
			end else if (gi == OPS_PORT_WRITE_BIT) begin : g_pw
				assign src_ops_word[gi] = OPS_PORT_WRITE_VAL;
				assign dst_ops_word[gi] = OPS_PORT_WRITE_VAL;
			end else begin : g_ops_rsvd
				assign src_ops_word[gi] = 1'b0;
				assign dst_ops_word[gi] = 1'b0;
			end
		end
	endgenerate

	// Address decode, one decoder per channel so reads and writes never wait on each other
	crb_dec_if rd_dec ();
	crb_dec_if wr_dec ();

	assign rd_dec.addr = s_axi_araddr;
	assign wr_dec.addr = s_axi_awaddr;

	crb_decode u_rd_decode (
		.dec(rd_dec)
	);

	crb_decode u_wr_decode (
		.dec(wr_dec)
	);

	// Read data selection
	wire [DATA_W-1:0] rdata_nxt;
	wire [1:0] rresp_nxt;
	wire rd_mapped;

	assign rd_mapped = (rd_dec.sel != SEL_NONE);
	assign rdata_nxt = (rd_dec.sel == SEL_ASM) ? asm_info_word :
		(rd_dec.sel == SEL_FEAT) ? features_word :
		(rd_dec.sel == SEL_SRC) ? src_ops_word :
		(rd_dec.sel == SEL_DST) ? dst_ops_word :
		WORD_ZERO;
	assign rresp_nxt = rd_mapped ? RESP_OKAY : RESP_DECERR;

	// Read channel handshake
	logic arready_r;
	logic rvalid_r;
	logic [DATA_W-1:0] rdata_r;
	logic [1:0] rresp_r;
	wire ar_offer;
	wire ar_take;
	wire r_done;
	wire arready_nxt;
	wire rvalid_nxt;

	// Ready is offered only while idle, so one read is in flight at a time
	assign ar_offer = s_axi_arvalid && !arready_r && !rvalid_r;
	assign ar_take = s_axi_arvalid && arready_r;
	assign r_done = rvalid_r && s_axi_rready;
	assign arready_nxt = ar_offer;
	assign rvalid_nxt = ar_take || (rvalid_r && !r_done);

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			arready_r <= 1'b0;
			rvalid_r <= 1'b0;
		end else if (ce) begin
			arready_r <= arready_nxt;
			rvalid_r <= rvalid_nxt;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata_r <= WORD_ZERO;
			rresp_r <= RESP_OKAY;
		end else if (ce && ar_take) begin
			rdata_r <= rdata_nxt;
			rresp_r <= rresp_nxt;
		end
	end

	// Write channel handshake: address and data are taken together
	logic awready_r;
	logic wready_r;
	logic bvalid_r;
	logic [1:0] bresp_r;
	wire aw_offer;
	wire aw_take;
	wire b_done;
	wire bvalid_nxt;
	wire [1:0] bresp_nxt;

	assign aw_offer = s_axi_awvalid && s_axi_wvalid && !awready_r && !bvalid_r;
	assign aw_take = awready_r && s_axi_awvalid && s_axi_wvalid;
	assign b_done = bvalid_r && s_axi_bready;
	assign bvalid_nxt = aw_take || (bvalid_r && !b_done);
	// Write data, strobes and protection are dropped: nothing here is writable
	assign bresp_nxt = (wr_dec.sel != SEL_NONE) ? RESP_OKAY : RESP_DECERR;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			awready_r <= 1'b0;
			wready_r <= 1'b0;
			bvalid_r <= 1'b0;
		end else if (ce) begin
			awready_r <= aw_offer;
			wready_r <= aw_offer;
			bvalid_r <= bvalid_nxt;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			bresp_r <= RESP_OKAY;
		end else if (ce && aw_take) begin
			bresp_r <= bresp_nxt;
		end
	end

	// Device ID width steer for the transport logic
	logic dev_id_16b_r;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			dev_id_16b_r <= 1'b0;
		end else if (ce) begin
			dev_id_16b_r <= features_word[FEAT_LARGE_SYS_BIT];
		end
	end

	// Operation words feed only the read mux, never any control path
	assign s_axi_arready = arready_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;
	assign s_axi_awready = awready_r;
	assign s_axi_wready = wready_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign dev_id_16b = dev_id_16b_r;
endmodule : crb_reg_bank

// File: tb/crb_reg_bank_asserts.sv
`timescale 1ns/1ps
module crb_chk (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [crb_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [crb_pkg::DATA_W-1:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic dev_id_16b
);
	import crb_pkg::*;
	logic [ADDR_W-1:0] a_q;
	wire feat = a_q == OFF_FEATURES;
	wire ops = a_q == OFF_SRC_OPS || a_q == OFF_DST_OPS;
	wire unm = a_q < OFF_ASM_INFO || a_q > OFF_CAP_LAST;
	// Address of the read in flight, to judge the word it returns
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) a_q <= '0;
		else if (s_axi_arvalid && s_axi_arready) a_q <= s_axi_araddr & WORD_MASK;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read answer late");
	a_ar_busy: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data not held");
	a_wr_pair: assert property (s_axi_awready |-> s_axi_wready && s_axi_awvalid && s_axi_wvalid)
		else $error("write halves not paired");
	a_wr_answer: assert property (s_axi_awready |=> s_axi_bvalid) else $error("write answer late");
	a_feat_fixed: assert property (s_axi_rvalid && feat |-> s_axi_rdata[28:6] == 23'h0 && s_axi_rdata[3:0] == 4'h9)
		else $error("fixed feature bits wrong");
	a_ops_fixed: assert property (s_axi_rvalid && ops |-> s_axi_rdata[31:16] == 16'h0 && s_axi_rdata[2:0] == 3'h0)
		else $error("fixed operation bits wrong");
	a_unmapped: assert property (s_axi_rvalid && unm |-> s_axi_rresp == RESP_DECERR && s_axi_rdata == WORD_ZERO)
		else $error("unmapped read answered");
	a_dev_id: assert property (s_axi_rvalid && feat |-> s_axi_rdata[4] == dev_id_16b)
		else $error("device id width disagrees");
	c_read: cover property (s_axi_rvalid && s_axi_rready);
	c_write: cover property (s_axi_bvalid && s_axi_bready);
	c_unm: cover property (s_axi_rvalid && unm);
endmodule : crb_chk

// File: tb/crb_host.sv
`timescale 1ns/1ps
module crb_host (
	input wire logic clk,
	output logic s_axi_awvalid,
	input wire logic s_axi_awready,
	output logic [crb_pkg::ADDR_W-1:0] s_axi_awaddr,
	output logic s_axi_wvalid,
	input wire logic s_axi_wready,
	output logic [crb_pkg::DATA_W-1:0] s_axi_wdata,
	input wire logic s_axi_bvalid,
	output logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	output logic s_axi_arvalid,
	input wire logic s_axi_arready,
	output logic [crb_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_rvalid,
	output logic s_axi_rready,
	input wire logic [1:0] s_axi_rresp,
	input wire logic [crb_pkg::DATA_W-1:0] s_axi_rdata
);
	import crb_pkg::*;
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
	end
	// Accept is held off w cycles to show a slow fabric
	task rd(input logic [ADDR_W-1:0] a, input int w, output logic [DATA_W-1:0] d, output logic [1:0] r);
		@(negedge clk);
		s_axi_araddr = a;
		s_axi_arvalid = 1'b1;
		while (!s_axi_arready) @(negedge clk);
		@(negedge clk);
		s_axi_arvalid = 1'b0;
		// Released lines must not look valid
		s_axi_araddr = ~a;
		while (!s_axi_rvalid) @(negedge clk);
		repeat (w) @(negedge clk);
		s_axi_rready = 1'b1;
		d = s_axi_rdata;
		r = s_axi_rresp;
		@(negedge clk);
		s_axi_rready = 1'b0;
	endtask : rd
	task wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] dt, input int w, output logic [1:0] r);
		@(negedge clk);
		s_axi_awaddr = a;
		s_axi_wdata = dt;
		{s_axi_awvalid, s_axi_wvalid} = 2'h3;
		while (!s_axi_awready) @(negedge clk);
		@(negedge clk);
		{s_axi_awvalid, s_axi_wvalid} = 2'h0;
		s_axi_awaddr = ~a;
		s_axi_wdata = ~dt;
		while (!s_axi_bvalid) @(negedge clk);
		repeat (w) @(negedge clk);
		s_axi_bready = 1'b1;
		r = s_axi_bresp;
		@(negedge clk);
		s_axi_bready = 1'b0;
	endtask : wr
endmodule : crb_host

// File: tb/tb_crb_reg_bank.sv
`timescale 1ns/1ps
module tb_crb_reg_bank;
	import crb_pkg::*;
	localparam logic [15:0] REV = 16'hA5C3;
	localparam logic [12:0] SRC = 13'h0AB5;
	localparam logic [12:0] DST = 13'h1542;
	localparam logic [31:0] FEAT = {3'b101, 22'h0, 1'b0, 2'b11, FEAT_EXT_FEAT_VAL, EXT_ADDR_34};
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, dev_id_16b;
	logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
	logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata, d;
	logic [1:0] s_axi_bresp, s_axi_rresp, r, r2;
	logic ce = 1'b1;
	logic [2:0] s_axi_awprot = 3'h0;
	logic [2:0] s_axi_arprot = 3'h0;
	logic [STRB_W-1:0] s_axi_wstrb = 4'hF;
	int err_total = 0;
	int tests_run = 0;
	int cyc = 0;
	logic [23:0] ra [12] = '{24'h00000C, 24'h00000E, 24'h000010, 24'h000014, 24'h000018, 24'h00001F,
		24'h000020, 24'h00003C, 24'h000000, 24'h000008, 24'h000040, 24'hFFFFFC};
	logic [31:0] rx [12] = '{{REV, EXT_PTR_DEFAULT}, {REV, EXT_PTR_DEFAULT}, FEAT, WORD_ZERO,
		{16'h0, SRC, 3'h0}, {16'h0, DST, 3'h0}, WORD_ZERO, WORD_ZERO, WORD_ZERO, WORD_ZERO, WORD_ZERO, WORD_ZERO};
	crb_reg_bank #(.ASM_REVISION(REV), .ROLE_BRIDGE(1'b1), .ROLE_MEMORY(1'b0), .ROLE_PROCESSOR(1'b1),
		.CRF_SUPPORT(1'b1), .LARGE_SYSTEM(1'b1), .SRC_OPS(SRC), .DST_OPS(DST)) i_dut (
		.*);
	crb_host i_host (.*);
	always #50 clk = ~clk;
	// Whole run needs a few hundred cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			err_total++;
			stop_test();
		end
	end
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task chkr(input string n, input logic [1:0] e, input logic [1:0] g);
		tests_run++;
		if (g !== e) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask : chkr
	task rst();
		arst_n = 1'b0;
		repeat (3) @(negedge clk);
		arst_n = 1'b1;
	endtask : rst
	task stop_test();
		$display("Mismatches %0d in %0d checks", err_total, tests_run);
		if (err_total == 0 && tests_run > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : stop_test
	initial begin
		rst();
		// Steer output is a flop: it shows the build value one edge after release
		@(negedge clk);
		chk("dev_id_16b", 32'h1, {31'h0, dev_id_16b});
		// Second pass proves the writes changed nothing
		for (int p = 0; p < 2; p++) begin
			for (int i = 0; i < 12; i++) begin
				// Protection and strobes vary: none of them may alter a word
				s_axi_arprot = 3'(i);
				s_axi_awprot = 3'(i);
				s_axi_wstrb = 4'(i);
				i_host.rd(ra[i], i % 3, d, r);
				chk("rdata", rx[i], d);
				chkr("rresp", (i < 8) ? RESP_OKAY : RESP_DECERR, r);
				if (p == 0) i_host.wr(ra[i], 32'hFFFFFFFF, i % 2, r);
				if (p == 0) chkr("bresp", (i < 8) ? RESP_OKAY : RESP_DECERR, r);
			end
		end
		fork
			i_host.rd(OFF_SRC_OPS, 0, d, r);
			i_host.wr(OFF_SRC_OPS, WORD_ZERO, 2, r2);
		join
		chk("rdata", rx[4], d);
		chkr("bresp", RESP_OKAY, r2);
		// Low enable freezes the read; a long answer hold would show if it slipped through
		ce = 1'b0;
		fork
			i_host.rd(OFF_DST_OPS, 6, d, r);
			begin
				repeat (4) @(negedge clk);
				chk("frozen", WORD_ZERO, {30'h0, s_axi_arready, s_axi_rvalid});
				ce = 1'b1;
			end
		join
		chk("rdata", rx[5], d);
		chkr("rresp", RESP_OKAY, r);
		rst();
		i_host.rd(OFF_FEATURES, 1, d, r);
		chk("rdata", FEAT, d);
		stop_test();
	end
endmodule : tb_crb_reg_bank
bind crb_reg_bank crb_chk i_chk (.*);
